/* adc_pin_pkg.sv */
package adc_pin_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL1 = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_RES_HI = 8'h08;
    localparam logic [7:0] OFS_RES_LO = 8'h0c;
    localparam logic [7:0] OFS_CMP_HI = 8'h10;
    localparam logic [7:0] OFS_CMP_LO = 8'h14;
    localparam logic [7:0] OFS_CONFIG = 8'h18;
    localparam logic [7:0] OFS_PIN0 = 8'h1c;
    localparam logic [7:0] OFS_PIN1 = 8'h20;
    localparam logic [7:0] OFS_PIN2 = 8'h24;
    // field positions
    localparam int CTRL1_DONE_BIT = 7;
    localparam int CTRL1_IEN_BIT = 6;
    localparam int CTRL1_CONT_BIT = 5;
    localparam int CTRL1_CH_LSB = 0;
    localparam int CTRL2_ACT_BIT = 7;
    localparam int CTRL2_CFE_BIT = 5;
    localparam int CTRL2_CGT_BIT = 4;
    localparam int CFG_DIV_LSB = 5;
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_SRC_LSB = 0;
    // reset values
    localparam logic [7:0] CTRL1_RESET = 8'h1f;
    localparam logic [7:0] CTRL2_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] PIN_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    // codes
    localparam logic [1:0] SRC_BUS = 2'h0;
    localparam logic [1:0] SRC_BUS_HALF = 2'h1;
    localparam logic [1:0] SRC_ALT = 2'h2;
    localparam logic [1:0] SRC_ASYNC = 2'h3;
    localparam logic [1:0] MODE_10 = 2'h2;
    localparam logic [4:0] CH_OFF = 5'h1f;
    // timing: sample phase length in converter clock ticks
    localparam logic [3:0] SAMPLE_TICKS = 4'h4;
endpackage : adc_pin_pkg

/* adc_clock_divider.sv */
`timescale 1ns/1ps
module adc_clock_divider (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // source tick and ratio
    input wire logic src_tick,
    input wire logic [1:0] div_sel,
    // divided converter clock tick
    output logic conv_tick
);
    logic [2:0] cnt_q;
    logic [2:0] limit;

    // ratio 1, 2, 4 or 8 source ticks per converter tick
    always_comb begin
        case (div_sel)
            2'h0: limit = 3'h0;
            2'h1: limit = 3'h1;
            2'h2: limit = 3'h3;
            default: limit = 3'h7;
        endcase
    end

    // counter and registered tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 3'h0;
            conv_tick <= 1'b0;
        end else begin
            conv_tick <= 1'b0;
            if (src_tick) begin
                if (cnt_q >= limit) begin
                    cnt_q <= 3'h0;
                    conv_tick <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 3'h1;
                end
            end
        end
    end
endmodule : adc_clock_divider

/* adc_pin_ctrl.sv */
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module adc_pin_ctrl #(
    parameter logic [23:0] CHANNEL_PRESENT = 24'hffffff,
    parameter logic [3:0] SAMPLE_LEN = adc_pin_pkg::SAMPLE_TICKS
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // clock sources and power mode
    input wire logic ALT_CLK_IN,
    input wire logic ASYNC_CLK_IN,
    input wire logic STOP_MODE,
    output logic ASYNC_OSC_EN,
    // analog front end
    input wire logic COMP_IN,
    output logic [4:0] CHANNEL,
    output logic [10:0] DAC_CODE,
    output logic SAMPLE_EN,
    output logic ANALOG_POWER_EN,
    output logic CONV_TICK,
    output logic IRQ,
    // port logic side
    input wire logic [23:0] PORT_OUT,
    input wire logic [23:0] PORT_OE,
    input wire logic [23:0] PORT_PULLUP,
    output logic [23:0] PORT_IN,
    // pad side
    input wire logic [23:0] PAD_IN,
    output logic [23:0] PAD_OUT,
    output logic [23:0] PAD_OE,
    output logic [23:0] PAD_PULLUP,
    output logic [23:0] PAD_IBUF_EN
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SAMPLE = 4'b0010,
        ST_CONVERT = 4'b0100,
        ST_FINISH = 4'b1000
    } state_type;

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic ack_q;
    logic acc, wr, rd_res_lo;
    logic wr_ctrl1, wr_ctrl2, wr_cfg, wr_cmp;
    logic [7:0] ctrl1_q, ctrl2_q, cfg_q, cmp_hi_q, cmp_lo_q;
    logic [7:0] res_hi_q, res_lo_q, rd_data;
    logic [7:0] pin0_q, pin1_q, pin2_q;
    logic done_q;
    logic [1:0] src_sel, div_sel;
    logic mode10, ch_off, cont_en;
    logic [2:0] alt_q, async_q;
    logic [1:0] comp_q;
    logic half_q, src_tick, conv_tick;
    state_type state_q;
    logic [10:0] sar_q, sar_d;
    logic [3:0] bit_q, msb;
    logic [3:0] smp_q;
    logic start, abort, step, pend_q;
    logic [1:0] settle_q;
    logic [11:0] sum10;
    logic [9:0] sum8;
    logic [9:0] r10, cmp_val, res_val;
    logic [7:0] r8;
    logic cond, store_fire;
    logic [23:0] dis_eff;
    logic [23:0] pad_s1_q, pad_s2_q;

    // reset release through two flops
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // bus decode; reads are taken before ack, writes land at the ack edge
    // so a write takes effect exactly where the master sees ack
    assign acc = CYC_I & STB_I & ~ack_q;
    assign wr = CYC_I & STB_I & ack_q & WE_I & SEL_I[0];
    assign wr_ctrl1 = wr && ADR_I == adc_pin_pkg::OFS_CTRL1;
    assign wr_ctrl2 = wr && ADR_I == adc_pin_pkg::OFS_CTRL2;
    assign wr_cfg = wr && ADR_I == adc_pin_pkg::OFS_CONFIG;
    assign wr_cmp = wr && (ADR_I == adc_pin_pkg::OFS_CMP_HI
        || ADR_I == adc_pin_pkg::OFS_CMP_LO);
    assign rd_res_lo = acc && !WE_I && ADR_I == adc_pin_pkg::OFS_RES_LO;

    // ack answers one edge after the request, unmapped reads give zero
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            DAT_O <= 32'h0;
        end else begin
            ack_q <= acc;
            if (acc && !WE_I) begin
                DAT_O <= {24'h0, rd_data};
            end
        end
    end
    assign ACK_O = ack_q;

    // read mux
    always_comb begin
        case (ADR_I)
            adc_pin_pkg::OFS_CTRL1: rd_data = {done_q, ctrl1_q[6:0]};
            adc_pin_pkg::OFS_CTRL2: rd_data = {state_q != ST_IDLE,
                ctrl2_q[6:0]};
            adc_pin_pkg::OFS_RES_HI: rd_data = res_hi_q;
            adc_pin_pkg::OFS_RES_LO: rd_data = res_lo_q;
            adc_pin_pkg::OFS_CMP_HI: rd_data = cmp_hi_q;
            adc_pin_pkg::OFS_CMP_LO: rd_data = cmp_lo_q;
            adc_pin_pkg::OFS_CONFIG: rd_data = cfg_q;
            adc_pin_pkg::OFS_PIN0: rd_data = pin0_q;
            adc_pin_pkg::OFS_PIN1: rd_data = pin1_q;
            adc_pin_pkg::OFS_PIN2: rd_data = pin2_q;
            default: rd_data = 8'h0;
        endcase
    end

    // control and configuration registers
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1_q <= adc_pin_pkg::CTRL1_RESET;
            ctrl2_q <= adc_pin_pkg::CTRL2_RESET;
            cfg_q <= adc_pin_pkg::CONFIG_RESET;
            cmp_hi_q <= adc_pin_pkg::CMP_RESET;
            cmp_lo_q <= adc_pin_pkg::CMP_RESET;
        end else begin
            if (wr_ctrl1) begin
                ctrl1_q <= {1'b0, DAT_I[6:0]};
            end
            if (wr_ctrl2) begin
                ctrl2_q <= {2'h0, DAT_I[5:4], 4'h0};
            end
            if (wr_cfg) begin
                cfg_q <= DAT_I[7:0];
            end
            if (wr && ADR_I == adc_pin_pkg::OFS_CMP_HI) begin
                cmp_hi_q <= {6'h0, DAT_I[1:0]};
            end
            if (wr && ADR_I == adc_pin_pkg::OFS_CMP_LO) begin
                cmp_lo_q <= DAT_I[7:0];
            end
        end
    end

    // pin-disable registers, all bits stored even for absent pins
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin0_q <= adc_pin_pkg::PIN_RESET;
            pin1_q <= adc_pin_pkg::PIN_RESET;
            pin2_q <= adc_pin_pkg::PIN_RESET;
        end else begin
            if (wr && ADR_I == adc_pin_pkg::OFS_PIN0) begin
                pin0_q <= DAT_I[7:0];
            end
            if (wr && ADR_I == adc_pin_pkg::OFS_PIN1) begin
                pin1_q <= DAT_I[7:0];
            end
            if (wr && ADR_I == adc_pin_pkg::OFS_PIN2) begin
                pin2_q <= DAT_I[7:0];
            end
        end
    end

    // field views
    assign src_sel = cfg_q[adc_pin_pkg::CFG_SRC_LSB +: 2];
    assign div_sel = cfg_q[adc_pin_pkg::CFG_DIV_LSB +: 2];
    // reserved resolution codes behave as 8-bit
    assign mode10 = cfg_q[adc_pin_pkg::CFG_MODE_LSB +: 2]
        == adc_pin_pkg::MODE_10;
    assign ch_off = ctrl1_q[4:0] == adc_pin_pkg::CH_OFF;
    assign cont_en = ctrl1_q[adc_pin_pkg::CTRL1_CONT_BIT];

    // pin clocks and comparator pass two flops before use
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            alt_q <= 3'h0;
            async_q <= 3'h0;
            comp_q <= 2'h0;
            half_q <= 1'b0;
        end else begin
            alt_q <= {alt_q[1:0], ALT_CLK_IN};
            async_q <= {async_q[1:0], ASYNC_CLK_IN};
            comp_q <= {comp_q[0], COMP_IN};
            half_q <= ~half_q;
        end
    end

    // source tick select; edge detect looks at stages two and three
    always_comb begin
        case (src_sel)
            adc_pin_pkg::SRC_BUS: src_tick = 1'b1;
            adc_pin_pkg::SRC_BUS_HALF: src_tick = half_q;
            adc_pin_pkg::SRC_ALT: src_tick = alt_q[1] & ~alt_q[2];
            default: src_tick = async_q[1] & ~async_q[2];
        endcase
    end

    // range of the resulting rate is left to software
    adc_clock_divider u_div (
        .clk(CLK),
        .rst_n(rst_n),
        .src_tick(src_tick),
        .div_sel(div_sel),
        .conv_tick(conv_tick)
    );
    assign CONV_TICK = conv_tick;

    // oscillator runs whenever busy on it, stop mode does not gate it
    assign ASYNC_OSC_EN = src_sel == adc_pin_pkg::SRC_ASYNC
        && state_q != ST_IDLE;

    // start on control write with a live channel; config writes abort
    assign start = wr_ctrl1 && DAT_I[4:0] != adc_pin_pkg::CH_OFF;
    assign abort = wr_ctrl2 || wr_cfg || wr_cmp
        || (wr_ctrl1 && DAT_I[4:0] == adc_pin_pkg::CH_OFF)
        || ch_off
        || (STOP_MODE && src_sel != adc_pin_pkg::SRC_ASYNC);
    assign msb = mode10 ? 4'ha : 4'h8;

    // one successive approximation step
    always_comb begin
        sar_d = sar_q;
        sar_d[bit_q] = comp_q[1];
        if (bit_q != 4'h0) begin
            sar_d[4'(bit_q - 4'h1)] = 1'b1;
        end
    end

    // comparator answer is two flops late; a trial code is judged only
    // once its own answer has arrived, ticks seen meanwhile are kept
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            settle_q <= 2'h0;
            pend_q <= 1'b0;
        end else if (state_q != ST_CONVERT || step) begin
            settle_q <= 2'h0;
            pend_q <= 1'b0;
        end else begin
            settle_q <= (settle_q == 2'h2) ? settle_q : settle_q + 2'h1;
            pend_q <= pend_q | conv_tick;
        end
    end
    assign step = state_q == ST_CONVERT && settle_q == 2'h2
        && (conv_tick || pend_q);

    // sequencer; a fresh start overrides everything, abort included
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            sar_q <= 11'h0;
            bit_q <= 4'h0;
            smp_q <= 4'h0;
        end else if (start) begin
            state_q <= ST_SAMPLE;
            smp_q <= 4'h0;
        end else if (abort) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_SAMPLE: begin
                    if (conv_tick) begin
                        if (smp_q >= SAMPLE_LEN - 4'h1) begin
                            state_q <= ST_CONVERT;
                            bit_q <= msb;
                            sar_q <= 11'(11'h001 << msb);
                        end else begin
                            smp_q <= smp_q + 4'h1;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (step) begin
                        sar_q <= sar_d;
                        if (bit_q == 4'h0) begin
                            state_q <= ST_FINISH;
                        end else begin
                            bit_q <= bit_q - 4'h1;
                        end
                    end
                end
                ST_FINISH: begin
                    // idle unless continuous
                    state_q <= cont_en ? ST_SAMPLE : ST_IDLE;
                    smp_q <= 4'h0;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // analog side outputs; power off while idle
    assign ANALOG_POWER_EN = state_q != ST_IDLE;
    assign SAMPLE_EN = state_q == ST_SAMPLE;
    assign DAC_CODE = sar_q;
    assign CHANNEL = ctrl1_q[4:0];

    // round half up, saturating at full scale
    assign sum10 = {1'b0, sar_q} + 12'h001;
    assign sum8 = {1'b0, sar_q[8:0]} + 10'h001;
    assign r10 = sum10[11] ? 10'h3ff : sum10[10:1];
    assign r8 = sum8[9] ? 8'hff : sum8[8:1];

    // compare against limit in either resolution
    assign res_val = mode10 ? r10 : {2'h0, r8};
    assign cmp_val = mode10 ? {cmp_hi_q[1:0], cmp_lo_q} : {2'h0, cmp_lo_q};
    assign cond = ctrl2_q[adc_pin_pkg::CTRL2_CGT_BIT] ? res_val >= cmp_val
        : res_val < cmp_val;
    assign store_fire = state_q == ST_FINISH && !start && !abort
        && (!ctrl2_q[adc_pin_pkg::CTRL2_CFE_BIT] || cond);

    // result registers keep last value on abort
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            res_hi_q <= adc_pin_pkg::RESULT_RESET;
            res_lo_q <= adc_pin_pkg::RESULT_RESET;
        end else if (store_fire) begin
            if (mode10) begin
                res_hi_q <= {6'h0, r10[9:8]};
                res_lo_q <= r10[7:0];
            end else begin
                res_hi_q <= 8'h0;
                res_lo_q <= r8;
            end
        end
    end

    // done flag; a store in the clearing cycle wins
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else if (store_fire) begin
            done_q <= 1'b1;
        end else if (wr_ctrl1 || rd_res_lo) begin
            done_q <= 1'b0;
        end
    end
    assign IRQ = done_q & ctrl1_q[adc_pin_pkg::CTRL1_IEN_BIT];

    // only pins that exist may be cut off from the port
    assign dis_eff = {pin2_q, pin1_q, pin0_q} & CHANNEL_PRESENT;

    // pad input crosses in before gating
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pad_s1_q <= 24'h0;
            pad_s2_q <= 24'h0;
        end else begin
            pad_s1_q <= PAD_IN;
            pad_s2_q <= pad_s1_q;
        end
    end

    // pad controls registered; disabled bit overrides port enable, pull-up and input, while the output value passes through
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PAD_OUT <= 24'h0;
            PAD_OE <= 24'h0;
            PAD_PULLUP <= 24'h0;
            PAD_IBUF_EN <= 24'h0;
            PORT_IN <= 24'h0;
        end else begin
            PAD_OUT <= PORT_OUT;
            PAD_OE <= PORT_OE & ~dis_eff;
            PAD_PULLUP <= PORT_PULLUP & ~dis_eff;
            PAD_IBUF_EN <= ~dis_eff;
            PORT_IN <= pad_s2_q & ~dis_eff;
        end
    end

    a_src_reset_bus: assert property (
        @(posedge CLK) $rose(rst_n) |-> src_sel == 2'h0 && div_sel == 2'h0)
        else $error("source select not bus clock after reset");
    a_pins_reset_zero: assert property (
        @(posedge CLK) $rose(rst_n) |-> dis_eff == 24'h0)
        else $error("pin-disable bits not zero after reset");
    a_div_by_one: assert property (
        @(posedge CLK) disable iff (!rst_n)
        (src_sel == 2'h0 && div_sel == 2'h0) [*3] |-> conv_tick)
        else $error("divide by one missed a tick");
    a_pad_oe_off: assert property (
        @(posedge CLK) disable iff (!rst_n)
        1 |=> (PAD_OE & $past(dis_eff)) == 24'h0)
        else $error("disabled pin still driven");
    a_port_in_zero: assert property (
        @(posedge CLK) disable iff (!rst_n)
        1 |=> (PORT_IN & $past(dis_eff)) == 24'h0)
        else $error("disabled pin reads nonzero");
    a_pullup_off: assert property (
        @(posedge CLK) disable iff (!rst_n)
        rst_n |=> PAD_PULLUP == ($past(PORT_PULLUP) & ~$past(dis_eff)))
        else $error("pull-up wrong on disabled pin");
    a_off_goes_idle: assert property (
        @(posedge CLK) disable iff (!rst_n)
        ch_off && !start |=> state_q == ST_IDLE && !ANALOG_POWER_EN)
        else $error("converter not off with channel all ones");
    a_done_irq: assert property (
        @(posedge CLK) disable iff (!rst_n)
        store_fire |=> done_q && IRQ == ctrl1_q[6])
        else $error("done flag or interrupt wrong after store");
    a_round_eight: assert property (
        @(posedge CLK) disable iff (!rst_n)
        store_fire && !mode10 |=> res_hi_q == 8'h0 && res_lo_q == $past(r8))
        else $error("8-bit result not stored in low register");
    a_async_runs: assert property (
        @(posedge CLK) disable iff (!rst_n)
        src_sel == adc_pin_pkg::SRC_ASYNC && STOP_MODE
        && state_q == ST_SAMPLE && !(CYC_I && STB_I)
        |=> state_q != ST_IDLE && ASYNC_OSC_EN)
        else $error("async oscillator stopped while busy");
endmodule : adc_pin_ctrl

/* pin_side_model.sv */
`timescale 1ns/1ps
module pin_side_model (
    // pad side
    input wire logic clk,
    input wire logic [23:0] pad_out,
    input wire logic [23:0] pad_oe,
    input wire logic [23:0] pad_pullup,
    output logic [23:0] pad_in,
    // port logic side
    output logic [23:0] port_out,
    output logic [23:0] port_oe,
    output logic [23:0] port_pullup,
    // analog side and clock sources
    input wire logic [10:0] level,
    input wire logic [10:0] dac_code,
    input wire logic osc_en,
    output logic comp_out,
    output logic alt_clk,
    output logic async_clk
);
    logic float_q = 1'b0;
    // port logic: every pin an output with pull-up asked for
    assign port_out = 24'ha5a5a5;
    assign port_oe = 24'hffffff;
    assign port_pullup = 24'hffffff;
    // a released pad without pull-up wanders, never keeps a value
    always_ff @(posedge clk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            if (pad_oe[i])
                pad_in[i] = pad_out[i];
            else if (pad_pullup[i])
                pad_in[i] = 1'b1;
            else
                pad_in[i] = float_q ^ i[0];
        end
    end
    // comparator: high while the input is at or above the trial code
    assign comp_out = level >= dac_code;
    // alternate clock runs free, six bus cycles a period
    initial begin
        alt_clk = 1'b0;
        // edges kept clear of the bus clock edges
        #5;
        forever #75 alt_clk = ~alt_clk;
    end
    // oscillator runs only while enabled, ten bus cycles a period
    initial begin
        async_clk = 1'b0;
        forever begin
            @(posedge osc_en);
            #5;
            while (osc_en) #125 async_clk = ~async_clk;
            async_clk = 1'b0;
        end
    end
endmodule : pin_side_model

/* tb.sv */
`timescale 1ns/1ps
module tb;
    logic clk, rst_b, cyc, stb, we, stop_mode, ack, osc_en, comp;
    logic smp, pwr, tick, irq, alt_clk, async_clk;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w, dat_r;
    logic [4:0] chan;
    logic [10:0] dac, level;
    logic [23:0] p_out, p_oe, p_pu, p_in, d_in, d_out, d_oe, d_pu, d_ib;
    int n_mismatch = 0;
    int num_checks = 0;
    // channels 20 to 23 have no pad behind them
    adc_pin_ctrl #(.CHANNEL_PRESENT(24'h0fffff), .SAMPLE_LEN(4'h4))
        i_adc_pin_ctrl (.CLK(clk), .RST_B(rst_b), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r),
        .ACK_O(ack), .ALT_CLK_IN(alt_clk), .ASYNC_CLK_IN(async_clk),
        .STOP_MODE(stop_mode), .ASYNC_OSC_EN(osc_en), .COMP_IN(comp),
        .CHANNEL(chan), .DAC_CODE(dac), .SAMPLE_EN(smp),
        .ANALOG_POWER_EN(pwr), .CONV_TICK(tick), .IRQ(irq),
        .PORT_OUT(p_out), .PORT_OE(p_oe), .PORT_PULLUP(p_pu), .PORT_IN(p_in),
        .PAD_IN(d_in), .PAD_OUT(d_out), .PAD_OE(d_oe), .PAD_PULLUP(d_pu),
        .PAD_IBUF_EN(d_ib));
    pin_side_model i_pin_side_model (.clk(clk), .pad_out(d_out),
        .pad_oe(d_oe), .pad_pullup(d_pu), .pad_in(d_in), .port_out(p_out),
        .port_oe(p_oe), .port_pullup(p_pu), .level(level), .dac_code(dac),
        .osc_en(osc_en), .comp_out(comp), .alt_clk(alt_clk),
        .async_clk(async_clk));
    // comparison of any result up to 24 bits
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one classic wishbone cycle; waits for ack, bounded
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] r);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50)
            n_mismatch++;
        r = dat_r[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        bus(1'b0, a, 8'h00, r);
        chk({16'h0, r}, {16'h0, e});
    endtask : rd
    // expecting no flag means waiting out the whole bound
    task automatic wait_irq(input logic e);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        chk({23'h0, irq}, {23'h0, e});
    endtask : wait_irq
    // bus cycles between two converter ticks
    task automatic tick_gap(input int e);
        int n;
        n = 0;
        while (tick !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1 && n < 200);
        chk(24'(n), 24'(e));
    endtask : tick_gap
    task automatic t_reset;
        rd(adc_pin_pkg::OFS_CTRL1, 8'h1f);
        rd(adc_pin_pkg::OFS_CONFIG, 8'h00);
        rd(adc_pin_pkg::OFS_PIN0, 8'h00);
        rd(adc_pin_pkg::OFS_PIN1, 8'h00);
        rd(adc_pin_pkg::OFS_PIN2, 8'h00);
        chk({23'h0, pwr}, 24'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_pins;
        logic [23:0] eff;
        eff = 24'hf35aa5 & 24'h0fffff;
        wr(adc_pin_pkg::OFS_PIN0, 8'ha5);
        wr(adc_pin_pkg::OFS_PIN1, 8'h5a);
        wr(adc_pin_pkg::OFS_PIN2, 8'hf3);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h00);
        rd(adc_pin_pkg::OFS_PIN0, 8'ha5);
        rd(adc_pin_pkg::OFS_PIN1, 8'h5a);
        rd(adc_pin_pkg::OFS_PIN2, 8'hf3);
        repeat (5) @(posedge clk);
        chk(d_oe, ~eff);
        chk(d_pu, ~eff);
        chk(d_ib, ~eff);
        chk(p_in, 24'ha5a5a5 & ~eff);
        wr(adc_pin_pkg::OFS_PIN0, 8'h00);
        wr(adc_pin_pkg::OFS_PIN1, 8'h00);
        wr(adc_pin_pkg::OFS_PIN2, 8'h00);
        repeat (5) @(posedge clk);
        chk(p_in, 24'ha5a5a5);
        $display("test pins done");
    endtask : t_pins
    task automatic t_convert;
        level <= 11'h2a7;
        wr(adc_pin_pkg::OFS_CONFIG, 8'h08);
        wr(adc_pin_pkg::OFS_CTRL1, 8'h43);
        @(posedge clk);
        chk({18'h0, chan, smp}, 24'h000007);
        wait_irq(1'b1);
        rd(adc_pin_pkg::OFS_CTRL1, 8'hc3);
        rd(adc_pin_pkg::OFS_RES_HI, 8'h01);
        rd(adc_pin_pkg::OFS_RES_LO, 8'h54);
        chk({22'h0, irq, pwr}, 24'h0);
        level <= 11'h7ff;
        wr(adc_pin_pkg::OFS_CONFIG, 8'h00);
        wr(adc_pin_pkg::OFS_CTRL1, 8'h43);
        wait_irq(1'b1);
        rd(adc_pin_pkg::OFS_RES_HI, 8'h00);
        rd(adc_pin_pkg::OFS_RES_LO, 8'hff);
        level <= 11'h2a7;
        wr(adc_pin_pkg::OFS_CONFIG, 8'h08);
        wr(adc_pin_pkg::OFS_CMP_HI, 8'h03);
        wr(adc_pin_pkg::OFS_CMP_LO, 8'hff);
        wr(adc_pin_pkg::OFS_CTRL2, 8'h30);
        wr(adc_pin_pkg::OFS_CTRL1, 8'h43);
        wait_irq(1'b0);
        rd(adc_pin_pkg::OFS_RES_LO, 8'hff);
        wr(adc_pin_pkg::OFS_CMP_HI, 8'h01);
        wr(adc_pin_pkg::OFS_CMP_LO, 8'h00);
        wr(adc_pin_pkg::OFS_CTRL1, 8'h43);
        wait_irq(1'b1);
        rd(adc_pin_pkg::OFS_RES_HI, 8'h01);
        wr(adc_pin_pkg::OFS_CTRL2, 8'h00);
        $display("test convert done");
    endtask : t_convert
    // each source and divider, running continuous, stopped by channel off
    task automatic t_clocks;
        logic [7:0] cfg [5] = '{8'h60, 8'h21, 8'h02, 8'h03, 8'h40};
        int gap [5] = '{8, 4, 6, 10, 4};
        for (int i = 0; i < 5; i++) begin
            level <= 11'h000;
            wr(adc_pin_pkg::OFS_CONFIG, cfg[i]);
            wr(adc_pin_pkg::OFS_CTRL1, 8'h23);
            if (i == 3)
                stop_mode <= 1'b1;
            tick_gap(gap[i]);
            wr(adc_pin_pkg::OFS_CTRL1, 8'h1f);
            stop_mode <= 1'b0;
            repeat (300) @(posedge clk);
            chk({23'h0, pwr}, 24'h0);
            rd(adc_pin_pkg::OFS_CTRL1, 8'h1f);
        end
        $display("test clocks done");
    endtask : t_clocks
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    // 40 MHz bus clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // watchdog well beyond the longest expected run
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
    // main sequence
    initial begin
        {rst_b, cyc, stb, we, stop_mode} = 5'h00;
        adr = 8'h00;
        sel = 4'h1;
        dat_w = 32'h0;
        level = 11'h000;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_pins();
        t_convert();
        t_clocks();
        test_done();
    end
endmodule : tb
